// [src/hbridge_cfg.svh]
// constants for the h-bridge fault and sleep controller
// Overview of operation
// - overcurrent past deglitch: bridge off, fault low
// - auto re-enable after retry period elapses
// - persisting overcurrent repeats trip and retry
// - each transistor checked separately; any trips
// - ground, supply, load shorts all trip
// - overcurrent ignores sense and regulation path
// - overtemperature: bridge off, fault low, retry
// - undervoltage: all off, logic reset, fault
// - split supply: lockout follows logic supply only
// - single supply: lockout follows motor supply
// - leave lockout only above rising threshold
// - leaving sleep needs supply, input high, wake elapsed
// - active: bridge, pump, logic enabled
// - either input high active; both low sleep
// - both low for sleep delay: sleep
// - sleep holds both outputs high impedance
// - input high past wake delay wakes device
// - fault exits when its recovery condition holds
// - restart inrush blanking on every activation
`ifndef HBRIDGE_CFG_SVH
`define HBRIDGE_CFG_SVH
`define CLK_PERIOD_NS 10
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OCP_DEGLITCH_NS 1000
`define RETRY_PERIOD_NS 1000000
`define SLEEP_DELAY_NS 100000
`define WAKE_DELAY_NS 100000
`define CNT_W 24
`define CNT_ONE 24'h000001
`define CNT_ZERO 24'h000000
// synchronised input vector layout
`define SYNC_W 12
`define SY_IN_A 0
`define SY_IN_B 1
`define SY_OC_LO 2
`define SY_OC_HI 5
`define SY_HOT 6
`define SY_COOL 7
`define SY_LOG_LOW 8
`define SY_LOG_OK 9
`define SY_MOT_LOW 10
`define SY_MOT_OK 11
// gate vector bit positions
`define G_HS_A 0
`define G_LS_A 1
`define G_HS_B 2
`define G_LS_B 3
`define GATES_OFF 4'h0
`endif

// [src/hbridge_pkg.sv]
// types for the h-bridge fault and sleep controller
package hbridge_pkg;
	typedef enum logic [1:0] {uvlo_st, sleep_st, active_st, fault_st} mode_type;
endpackage

// [src/pin_sync3.sv]
// three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] stable_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] stable_reg;
	genvar i;
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= async_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge core_clk_in) begin
				if (reset_in) begin
					stable_reg[i] <= 1'b0;
				end else if (s2_reg[i] == s3_reg[i]) begin
					stable_reg[i] <= s3_reg[i];
				end
			end
		end
	endgenerate
	assign stable_out = stable_reg;
endmodule

// [src/hbridge_fault_sleep_control.sv]
// protection and mode control for an h-bridge motor driver
`timescale 1ns/10ps
`include "hbridge_cfg.svh"
module hbridge_fault_sleep_control #(
	parameter logic [`CNT_W-1:0] RETRY_CYCLES = `CNT_W'(`CYC_UP(`RETRY_PERIOD_NS)),
	parameter logic [`CNT_W-1:0] SLEEP_CYCLES = `CNT_W'(`CYC_UP(`SLEEP_DELAY_NS)),
	parameter logic [`CNT_W-1:0] WAKE_CYCLES = `CNT_W'(`CYC_UP(`WAKE_DELAY_NS))
) (
	input wire logic core_clk_in,
	input wire logic reset_in,
	input wire logic drive_input_a_in,
	input wire logic drive_input_b_in,
	input wire logic [3:0] overcurrent_in,
	input wire logic thermal_over_in,
	input wire logic thermal_cool_in,
	input wire logic logic_supply_low_in,
	input wire logic logic_supply_ok_in,
	input wire logic motor_supply_low_in,
	input wire logic motor_supply_ok_in,
	input wire logic split_supply_in,
	input wire logic fault_flag_n_in,
	output logic fault_flag_n_out,
	output logic fault_flag_n_oe_n_out,
	output logic [3:0] gate_on_out,
	output logic bridge_hiz_out,
	output logic charge_pump_en_out,
	output logic internal_en_out,
	output logic inrush_restart_out
);
	localparam logic [`CNT_W-1:0] OCP_CYCLES = `CNT_W'(`CYC_UP(`OCP_DEGLITCH_NS));

	hbridge_pkg::mode_type state_reg;
	hbridge_pkg::mode_type state_next;
	logic [`SYNC_W-1:0] raw_vec;
	logic [`SYNC_W-1:0] sy_vec;
	logic split_reg;
	logic cause_hot_reg;
	logic cause_hot_next;
	logic [`CNT_W-1:0] oc_cnt_reg;
	logic [`CNT_W-1:0] retry_cnt_reg;
	logic [`CNT_W-1:0] sleep_cnt_reg;
	logic [`CNT_W-1:0] wake_cnt_reg;
	logic [3:0] gate_reg;
	logic [3:0] gate_next;
	logic hiz_reg;
	logic pump_reg;
	logic internal_reg;
	logic inrush_reg;
	logic flag_oe_n_reg;
	logic [3:0] oc_hit;
	wire logic in_a;
	wire logic in_b;
	wire logic any_in;
	wire logic oc_any;
	wire logic hot;
	wire logic cool;
	wire logic uvlo_enter;
	wire logic uvlo_exit;
	wire logic oc_trip;
	wire logic retry_done;
	wire logic sleep_done;
	wire logic wake_done;
	wire logic is_active;
	wire logic is_fault;
	wire logic is_sleep;
	wire logic is_uvlo;
	genvar g;

	// gate pattern for a pair of drive inputs; both high brakes on the low sides
	function automatic logic [3:0] gate_pattern(input logic a, input logic b);
		logic [3:0] p;
		p = `GATES_OFF;
		if (a && !b) begin
			p[`G_HS_A] = 1'b1;
			p[`G_LS_B] = 1'b1;
		end else if (!a && b) begin
			p[`G_HS_B] = 1'b1;
			p[`G_LS_A] = 1'b1;
		end else if (a && b) begin
			p[`G_LS_A] = 1'b1;
			p[`G_LS_B] = 1'b1;
		end
		return p;
	endfunction

	assign raw_vec = {motor_supply_ok_in, motor_supply_low_in, logic_supply_ok_in,
		logic_supply_low_in, thermal_cool_in, thermal_over_in, overcurrent_in,
		drive_input_b_in, drive_input_a_in};

	pin_sync3 #(
		.WIDTH(`SYNC_W)
	) u_sync (
		.core_clk_in(core_clk_in),
		.reset_in(reset_in),
		.async_in(raw_vec),
		.stable_out(sy_vec)
	);

	// supply variant strap is caught while reset is held
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			split_reg <= split_supply_in;
		end
	end

	assign in_a = sy_vec[`SY_IN_A];
	assign in_b = sy_vec[`SY_IN_B];
	assign any_in = in_a | in_b;
	assign hot = sy_vec[`SY_HOT];
	assign cool = sy_vec[`SY_COOL];

	// limit flags come straight from the per-transistor comparators, not from sensing
	generate
		for (g = 0; g < 4; g++) begin : g_oc
			assign oc_hit[g] = sy_vec[`SY_OC_LO + g];
		end
	endgenerate
	assign oc_any = |oc_hit;

	// split supply watches only the logic rail so the motor rail may collapse
	assign uvlo_enter = split_reg ? sy_vec[`SY_LOG_LOW] : sy_vec[`SY_MOT_LOW];
	assign uvlo_exit = split_reg ? sy_vec[`SY_LOG_OK] : sy_vec[`SY_MOT_OK];

	assign is_active = (state_reg == hbridge_pkg::active_st);
	assign is_fault = (state_reg == hbridge_pkg::fault_st);
	assign is_sleep = (state_reg == hbridge_pkg::sleep_st);
	assign is_uvlo = (state_reg == hbridge_pkg::uvlo_st);

	assign oc_trip = is_active && oc_any && (oc_cnt_reg == OCP_CYCLES - `CNT_ONE);
	assign retry_done = is_fault && (retry_cnt_reg == RETRY_CYCLES - `CNT_ONE);
	assign sleep_done = is_active && !any_in && (sleep_cnt_reg == SLEEP_CYCLES - `CNT_ONE);
	assign wake_done = is_sleep && any_in && (wake_cnt_reg == WAKE_CYCLES - `CNT_ONE);

	always_comb begin
		state_next = state_reg;
		cause_hot_next = cause_hot_reg;
		case (state_reg)
			hbridge_pkg::uvlo_st: begin
				if (uvlo_exit) begin
					state_next = hbridge_pkg::sleep_st;
				end
			end
			hbridge_pkg::sleep_st: begin
				if (wake_done) begin
					state_next = hbridge_pkg::active_st;
				end
			end
			hbridge_pkg::active_st: begin
				if (hot || oc_trip) begin
					state_next = hbridge_pkg::fault_st;
					cause_hot_next = hot;
				end else if (sleep_done) begin
					state_next = hbridge_pkg::sleep_st;
				end
			end
			hbridge_pkg::fault_st: begin
				// overcurrent rechecks through the deglitch after re-enable
				if (retry_done && (!cause_hot_reg || cool)) begin
					state_next = hbridge_pkg::active_st;
				end
			end
			default: begin
				state_next = hbridge_pkg::uvlo_st;
			end
		endcase
		if (uvlo_enter) begin
			state_next = hbridge_pkg::uvlo_st;
			cause_hot_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			state_reg <= hbridge_pkg::uvlo_st;
			cause_hot_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cause_hot_reg <= cause_hot_next;
		end
	end

	// each timer clears the moment its condition drops
	always_ff @(posedge core_clk_in) begin
		if (reset_in || !(is_active && oc_any) || uvlo_enter) begin
			oc_cnt_reg <= `CNT_ZERO;
		end else begin
			oc_cnt_reg <= oc_cnt_reg + `CNT_ONE;
		end
	end

	// a thermal retry that finds the die still hot starts a fresh period
	always_ff @(posedge core_clk_in) begin
		if (reset_in || !is_fault || retry_done || uvlo_enter) begin
			retry_cnt_reg <= `CNT_ZERO;
		end else begin
			retry_cnt_reg <= retry_cnt_reg + `CNT_ONE;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in || !is_active || any_in || uvlo_enter) begin
			sleep_cnt_reg <= `CNT_ZERO;
		end else begin
			sleep_cnt_reg <= sleep_cnt_reg + `CNT_ONE;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in || !is_sleep || !any_in || uvlo_enter) begin
			wake_cnt_reg <= `CNT_ZERO;
		end else begin
			wake_cnt_reg <= wake_cnt_reg + `CNT_ONE;
		end
	end

	// outputs follow the next state so they line up with state_reg
	assign gate_next = (state_next == hbridge_pkg::active_st) ?
		gate_pattern(in_a, in_b) : `GATES_OFF;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			gate_reg <= `GATES_OFF;
			hiz_reg <= 1'b1;
			pump_reg <= 1'b0;
			internal_reg <= 1'b0;
			inrush_reg <= 1'b0;
			flag_oe_n_reg <= 1'b0;
		end else begin
			gate_reg <= gate_next;
			hiz_reg <= (gate_next == `GATES_OFF);
			pump_reg <= (state_next == hbridge_pkg::active_st);
			internal_reg <= (state_next == hbridge_pkg::active_st) ||
				(state_next == hbridge_pkg::fault_st);
			inrush_reg <= (state_next == hbridge_pkg::active_st) && !is_active;
			flag_oe_n_reg <= !((state_next == hbridge_pkg::fault_st) ||
				(state_next == hbridge_pkg::uvlo_st));
		end
	end

	// open drain: the pin only ever pulls low, the level comes from the board
	assign fault_flag_n_out = 1'b0;
	assign fault_flag_n_oe_n_out = flag_oe_n_reg;
	assign gate_on_out = gate_reg;
	assign bridge_hiz_out = hiz_reg;
	assign charge_pump_en_out = pump_reg;
	assign internal_en_out = internal_reg;
	assign inrush_restart_out = inrush_reg;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_oc_ready;
		is_active && oc_any && !hot && (oc_cnt_reg == OCP_CYCLES - `CNT_ONE);
	endsequence

	sequence s_wake_ready;
		is_sleep && any_in && (wake_cnt_reg == WAKE_CYCLES - `CNT_ONE);
	endsequence

	a_oc_trip_shutdown: assert property (
		s_oc_ready and !uvlo_enter |=> is_fault && gate_on_out == `GATES_OFF
			&& !fault_flag_n_oe_n_out)
		else $error("overcurrent did not shut the bridge down");

	a_oc_retry_reenable: assert property (
		retry_done && !cause_hot_reg && !uvlo_enter |=> is_active ##0 inrush_restart_out)
		else $error("overcurrent retry did not re-enable");

	a_hot_retry_repeat: assert property (
		retry_done && cause_hot_reg && !cool && !uvlo_enter
			|=> is_fault && retry_cnt_reg == `CNT_ZERO)
		else $error("thermal retry did not restart");

	a_hot_trip_shutdown: assert property (
		is_active && hot && !uvlo_enter |=> is_fault && cause_hot_reg
			&& gate_on_out == `GATES_OFF)
		else $error("overtemperature did not shut down");

	a_uvlo_priority_hold: assert property (
		uvlo_enter |=> is_uvlo && !internal_en_out && !fault_flag_n_oe_n_out)
		else $error("undervoltage did not take over");

	a_uvlo_exit_hyst: assert property (
		is_uvlo && !uvlo_exit && !uvlo_enter |=> is_uvlo)
		else $error("lockout left without rising threshold");

	a_sleep_entry_hiz: assert property (
		sleep_done && !hot && !oc_trip && !uvlo_enter |=> is_sleep && bridge_hiz_out
			&& !charge_pump_en_out)
		else $error("sleep entry missed");

	a_sleep_outputs_off: assert property (
		is_sleep |-> gate_on_out == `GATES_OFF && bridge_hiz_out)
		else $error("bridge driven in sleep");

	a_wake_entry_inrush: assert property (
		s_wake_ready and !uvlo_enter |=> is_active && inrush_restart_out
			&& charge_pump_en_out)
		else $error("wake did not activate");

	a_active_only_entry: assert property (
		is_active && !$past(is_active) |-> $past(is_sleep) || $past(is_fault))
		else $error("active entered from lockout");

	a_oc_count_clear: assert property (
		is_active && !oc_any |=> oc_cnt_reg == `CNT_ZERO)
		else $error("deglitch count not cleared");

	a_flag_follows_fault: assert property (
		(is_fault || is_uvlo) |-> !fault_flag_n_oe_n_out && !fault_flag_n_out)
		else $error("fault line released during fault");

	a_drive_fwd_pair: assert property (
		is_active && in_a && !in_b && !hot && !oc_trip && !uvlo_enter
			|=> gate_on_out[`G_HS_A] && gate_on_out[`G_LS_B] && !gate_on_out[`G_HS_B]
			&& !gate_on_out[`G_LS_A])
		else $error("forward drive pattern wrong");

	a_brake_low_sides: assert property (
		is_active && in_a && in_b && !hot && !oc_trip && !uvlo_enter
			|=> gate_on_out[`G_LS_A] && gate_on_out[`G_LS_B] && !gate_on_out[`G_HS_A]
			&& !gate_on_out[`G_HS_B])
		else $error("brake pattern wrong");

	a_fault_bridge_off: assert property (
		is_fault |-> gate_on_out == `GATES_OFF && bridge_hiz_out && !charge_pump_en_out
			&& internal_en_out)
		else $error("bridge live during fault");

	a_uvlo_all_off: assert property (
		is_uvlo |-> gate_on_out == `GATES_OFF && !internal_en_out && !charge_pump_en_out)
		else $error("circuits live during lockout");

	a_wake_count_clear: assert property (
		is_sleep && !any_in |=> wake_cnt_reg == `CNT_ZERO)
		else $error("wake count not cleared");

	a_sleep_count_clear: assert property (
		is_active && any_in |=> sleep_cnt_reg == `CNT_ZERO)
		else $error("sleep count not cleared");

	a_inrush_one_cycle: assert property (
		inrush_restart_out |=> !inrush_restart_out)
		else $error("inrush restart longer than one cycle");

	a_wake_needs_input: assert property (
		is_active && $past(is_sleep) |-> $past(any_in))
		else $error("woke without a drive input");

	a_split_logic_only: assert property (
		split_reg && !is_uvlo && !sy_vec[`SY_LOG_LOW] |=> !is_uvlo)
		else $error("split supply locked out on motor rail");
endmodule

// [tb/host_model.sv]
// host model: drive pins and the pulled-up fault line
`timescale 1ns/10ps
module host_model (
	input wire logic clk_in,
	input wire logic cmd_a_in,
	input wire logic cmd_b_in,
	input wire logic oe_n_in,
	input wire logic data_in,
	output logic pin_a_out,
	output logic pin_b_out,
	output logic fault_pin_out
);
	initial begin
		pin_a_out = 1'b0;
		pin_b_out = 1'b0;
	end
	// pins move just after an edge and hold until the next command
	always @(posedge clk_in) begin
		pin_a_out <= #1 cmd_a_in;
		pin_b_out <= #1 cmd_b_in;
	end
	// pull-up: released or unknown drive reads high
	assign fault_pin_out = (oe_n_in === 1'b0) ? data_in : 1'b1;
endmodule

// [tb/tb_hbridge_fault_sleep_control.sv]
// testbench for the h-bridge fault and sleep controller
`timescale 1ns/10ps
module tb_hbridge_fault_sleep_control;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ca = 1'b0, cb = 1'b0, hot = 1'b0, cool = 1'b1;
	logic llow = 1'b0, lok = 1'b1, mlow = 1'b0, mok = 1'b1, split = 1'b0;
	logic [3:0] oc = 4'h0;
	logic pa, pb, fpin, fdat, oe_n, hiz, pump, inten, inrush;
	logic [3:0] gates;
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	initial forever #5 clk = ~clk;
	host_model u_host_model (.clk_in(clk), .cmd_a_in(ca), .cmd_b_in(cb),
		.oe_n_in(oe_n), .data_in(fdat), .pin_a_out(pa), .pin_b_out(pb),
		.fault_pin_out(fpin));
	// short counts keep the run brief
	hbridge_fault_sleep_control #(.RETRY_CYCLES(24'h000014),
		.SLEEP_CYCLES(24'h000010), .WAKE_CYCLES(24'h00000C))
		u_hbridge_fault_sleep_control (.core_clk_in(clk), .reset_in(rst),
		.drive_input_a_in(pa), .drive_input_b_in(pb), .overcurrent_in(oc),
		.thermal_over_in(hot), .thermal_cool_in(cool),
		.logic_supply_low_in(llow), .logic_supply_ok_in(lok),
		.motor_supply_low_in(mlow), .motor_supply_ok_in(mok),
		.split_supply_in(split), .fault_flag_n_in(fpin), .fault_flag_n_out(fdat),
		.fault_flag_n_oe_n_out(oe_n), .gate_on_out(gates), .bridge_hiz_out(hiz),
		.charge_pump_en_out(pump), .internal_en_out(inten),
		.inrush_restart_out(inrush));
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task chk(input logic [3:0] got, input logic [3:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wait_g(input logic [3:0] exp, output int n);
		n = 0;
		while (gates !== exp && n < 400) begin
			step(1);
			n++;
		end
		chk(gates, exp);
	endtask
	task wait_oe(input logic exp, output int n);
		n = 0;
		while (oe_n !== exp && n < 400) begin
			step(1);
			n++;
		end
		chk(4'(oe_n), 4'(exp));
	endtask
	task t_wake;
		int n;
		ca = 1'b1;
		wait_g(4'h9, n);
		chk(4'(n >= 12), 4'h1);
		chk({inrush, pump, inten, hiz}, 4'hE);
		chk(4'(fpin), 4'h1);
		step(1);
		chk(4'(inrush), 4'h0);
		cb = 1'b1;
		wait_g(4'hA, n);
		ca = 1'b0;
		wait_g(4'h6, n);
		$display("test wake done");
	endtask
	task t_ocp;
		int n;
		// two short pulses, together past the deglitch, must not trip
		oc = 4'h1;
		step(60);
		oc = 4'h0;
		step(10);
		oc = 4'h1;
		step(60);
		oc = 4'h0;
		step(10);
		chk(4'(oe_n), 4'h1);
		chk(gates, 4'h6);
		for (int i = 0; i < 4; i++) begin
			oc = 4'(1 << i);
			wait_oe(1'b0, n);
			chk(4'(n >= 100), 4'h1);
			chk(gates, 4'h0);
			chk({fpin, hiz, pump, inten}, 4'h5);
			wait_oe(1'b1, n);
			chk(4'(n >= 19), 4'h1);
			chk(4'(inrush), 4'h1);
			wait_oe(1'b0, n);
			chk(4'(n >= 100), 4'h1);
			oc = 4'h0;
			wait_oe(1'b1, n);
			wait_g(4'h6, n);
			step(110);
			chk(4'(fpin), 4'h1);
		end
		$display("test overcurrent done");
	endtask
	task t_hot;
		int n;
		hot = 1'b1;
		cool = 1'b0;
		wait_oe(1'b0, n);
		chk(4'(n <= 6), 4'h1);
		chk({fpin, hiz, pump, inten}, 4'h5);
		hot = 1'b0;
		step(45);
		chk(4'(fpin), 4'h0);
		cool = 1'b1;
		wait_oe(1'b1, n);
		chk(4'(n <= 25), 4'h1);
		chk(4'(inrush), 4'h1);
		wait_g(4'h6, n);
		$display("test thermal done");
	endtask
	task t_sleep;
		cb = 1'b0;
		step(9);
		chk(4'({hiz, pump}), 4'h3);
		step(16);
		chk(4'({hiz, pump, inten}), 4'h4);
		ca = 1'b1;
		step(6);
		ca = 1'b0;
		step(12);
		chk(gates, 4'h0);
		chk(4'(hiz), 4'h1);
		$display("test sleep done");
	endtask
	task t_uvlo;
		int n;
		ca = 1'b1;
		wait_g(4'h9, n);
		mlow = 1'b1;
		mok = 1'b0;
		wait_oe(1'b0, n);
		chk(4'(n <= 6), 4'h1);
		chk({fpin, hiz, pump, inten}, 4'h4);
		mlow = 1'b0;
		step(10);
		chk(4'(fpin), 4'h0);
		mok = 1'b1;
		wait_oe(1'b1, n);
		wait_g(4'h9, n);
		chk(4'(n >= 12), 4'h1);
		$display("test lockout done");
	endtask
	task t_split;
		int n;
		rst = 1'b1;
		split = 1'b1;
		step(6);
		rst = 1'b0;
		mlow = 1'b1;
		mok = 1'b0;
		wait_g(4'h9, n);
		chk(4'(fpin), 4'h1);
		llow = 1'b1;
		lok = 1'b0;
		wait_oe(1'b0, n);
		chk(4'(n <= 6), 4'h1);
		$display("test split supply done");
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ceiling well above the fewer than two thousand cycles the tests need
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report;
		end
	end
	initial begin
		step(6);
		rst = 1'b0;
		t_wake;
		t_ocp;
		t_hot;
		t_sleep;
		t_uvlo;
		t_split;
		final_report;
	end
endmodule
